//--- pkg/radio_framer_pkg.sv
// shared constants and carriers for the radio packet framer
package radio_framer_pkg;
  localparam logic [6:0]  RX_BUF_BASE      = 7'h60;
  localparam logic [6:0]  RX_BUF_LAST      = 7'h7f;
  localparam logic [6:0]  TX_BUF_BASE      = 7'h40;
  localparam logic [6:0]  TX_BUF_LAST      = 7'h5f;
  localparam logic [6:0]  TX_ADDR_OFS      = 7'h11;
  localparam logic [6:0]  RX_ADDR_OFS      = 7'h0e;
  localparam logic [6:0]  TX_LEN_OFS       = 7'h14;
  localparam logic [6:0]  RX_LEN_OFS       = 7'h15;
  localparam logic [6:0]  STATUS_OFS       = 7'h30;
  localparam logic [6:0]  CTRL_OFS         = 7'h31;
  localparam logic [23:0] ADDR_RESET       = 24'h12345b;
  localparam logic [4:0]  LEN_RESET        = 5'h00;
  localparam logic [7:0]  PREAMBLE_ZERO    = 8'h55;
  localparam logic [7:0]  PREAMBLE_ONE     = 8'haa;
  localparam logic [15:0] CRC_POLY         = 16'h1021;
  localparam logic [15:0] CRC_INIT         = 16'hffff;
  localparam int          FLAG_TAG_LSB     = 6;
  localparam int          FLAG_TYPE_BIT    = 5;
  localparam int          FLAG_LEN_LSB     = 0;
  localparam int          CTRL_SEND_BIT    = 0;
  localparam int          CTRL_RESEND_BIT  = 1;
  localparam int          CTRL_ACK_BIT     = 2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PRE  = 3'b001,
    TX_ADR  = 3'b011,
    TX_FLG  = 3'b010,
    TX_PLD  = 3'b110,
    TX_CRC  = 3'b111
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b000,
    RX_ADR  = 3'b001,
    RX_FLG  = 3'b011,
    RX_PLD  = 3'b010,
    RX_CRC  = 3'b110
  } rx_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_s;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
endpackage

//--- src/radio_packet_framer.sv
// packet framer: tx build, rx strip/check, duplicate filter, rx payload buffer
`timescale 1ns/1ps
module radio_packet_framer
  import radio_framer_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      srst,
  input  wire host_req_s host_req,
  output logic [7:0]     host_rdata,
  output logic           tx_bit,
  output logic           tx_active,
  input  wire logic      rx_bit_valid,
  input  wire logic      rx_bit,
  output logic           rx_packet_ok,
  output logic           rx_packet_error,
  output logic           ack_received,
  output logic           nack_received
);

  typedef struct packed {
    tx_state_e   tx_state;
    logic [5:0]  tx_cnt;
    logic [2:0]  tx_bitn;
    logic [7:0]  tx_sh;
    logic [15:0] tx_crc;
    logic        tx_is_ack;
    logic [1:0]  packet_sequence_tag;
    logic        tx_bit;
    logic        tx_active;
    logic [23:0] tx_addr;
    logic [23:0] rx_addr;
    logic [4:0]  tx_length_minus_one;
    logic [4:0]  rx_length_minus_one;
    rx_state_e   rx_state;
    logic [7:0]  rx_sh;
    logic [2:0]  rx_bitn;
    logic [5:0]  rx_cnt;
    logic [15:0] rx_crc;
    logic [15:0] rx_got;
    logic [7:0]  rx_flags;
    logic        last_valid;
    logic [1:0]  last_tag;
    logic [15:0] last_crc;
    logic [15:0] sent_crc;
    logic [7:0]  host_rdata;
    logic        rx_packet_ok;
    logic        rx_packet_error;
    logic        ack_received;
    logic        nack_received;
  } state_s;

  state_s st;
  state_s next_st;

  // payload buffers carry no reset: undefined until first use
  logic [7:0] tx_mem [32];
  logic [7:0] rx_mem [32];
  logic [7:0] rx_stage [32];
  logic       rx_byte_done;
  logic [7:0] rx_byte;
  logic       commit;

  assign rx_byte = {rx_bit, st.rx_sh[7:1]};
  assign rx_byte_done = rx_bit_valid && (st.rx_bitn == 3'd7);

  always_ff @(posedge core_clk) begin
    if (host_req.wr && host_req.addr >= TX_BUF_BASE && host_req.addr <= TX_BUF_LAST) begin
      tx_mem[host_req.addr[4:0]] <= host_req.wdata;
    end
    if (st.rx_state == RX_PLD && rx_byte_done) begin
      rx_stage[st.rx_cnt[4:0]] <= rx_byte;
    end
    if (commit) begin
      rx_mem <= rx_stage;
    end
  end

  always_comb begin
    logic [15:0] crc_nx;
    logic        dup;
    // a call result cannot be part-selected, so the byte step is staged here
    crc_nx  = crc_byte(st.tx_crc, st.tx_sh);
    dup     = 1'b0;
    commit  = 1'b0;
    next_st = st;
    next_st.rx_packet_ok    = 1'b0;
    next_st.rx_packet_error = 1'b0;
    next_st.ack_received    = 1'b0;
    next_st.nack_received   = 1'b0;

    // register port; reads answer one cycle after the request
    if (host_req.rd) begin
      if (host_req.addr >= RX_BUF_BASE) begin
        next_st.host_rdata = rx_mem[host_req.addr[4:0]];
      end else if (host_req.addr >= TX_BUF_BASE) begin
        next_st.host_rdata = tx_mem[host_req.addr[4:0]];
      end else if (host_req.addr == TX_LEN_OFS) begin
        next_st.host_rdata = {3'b000, st.tx_length_minus_one};
      end else if (host_req.addr == RX_LEN_OFS) begin
        next_st.host_rdata = {3'b000, st.rx_length_minus_one};
      end else if (host_req.addr >= TX_ADDR_OFS && host_req.addr <= TX_ADDR_OFS + 7'd2) begin
        next_st.host_rdata = st.tx_addr[8*(host_req.addr - TX_ADDR_OFS) +: 8];
      end else if (host_req.addr >= RX_ADDR_OFS && host_req.addr <= RX_ADDR_OFS + 7'd2) begin
        next_st.host_rdata = st.rx_addr[8*(host_req.addr - RX_ADDR_OFS) +: 8];
      end else if (host_req.addr == STATUS_OFS) begin
        next_st.host_rdata = {st.tx_active, st.last_valid, st.packet_sequence_tag, 4'h0};
      end else begin
        next_st.host_rdata = 8'h00;
      end
    end
    if (host_req.wr) begin
      if (host_req.addr == TX_LEN_OFS) begin
        next_st.tx_length_minus_one = host_req.wdata[4:0];
      end
      if (host_req.addr >= TX_ADDR_OFS && host_req.addr <= TX_ADDR_OFS + 7'd2) begin
        next_st.tx_addr[8*(host_req.addr - TX_ADDR_OFS) +: 8] = host_req.wdata;
      end
      if (host_req.addr >= RX_ADDR_OFS && host_req.addr <= RX_ADDR_OFS + 7'd2) begin
        next_st.rx_addr[8*(host_req.addr - RX_ADDR_OFS) +: 8] = host_req.wdata;
      end
    end

    // transmitter
    next_st.tx_bit = st.tx_sh[st.tx_bitn];
    if (st.tx_state != TX_IDLE) begin
      next_st.tx_bitn = st.tx_bitn + 3'd1;
    end
    unique case (st.tx_state)
      TX_IDLE: begin
        next_st.tx_active = 1'b0;
        if (host_req.wr && host_req.addr == CTRL_OFS && host_req.wdata[2:0] != 3'b000) begin
          next_st.tx_is_ack = host_req.wdata[CTRL_ACK_BIT];
          if (host_req.wdata[CTRL_SEND_BIT] && !host_req.wdata[CTRL_ACK_BIT]) begin
            next_st.packet_sequence_tag = st.packet_sequence_tag + 2'd1;
          end
          next_st.tx_sh     = st.tx_addr[0] ? PREAMBLE_ONE : PREAMBLE_ZERO;
          next_st.tx_bitn   = 3'd0;
          next_st.tx_cnt    = '0;
          next_st.tx_crc    = CRC_INIT;
          next_st.tx_active = 1'b1;
          next_st.tx_state  = TX_PRE;
        end
      end
      TX_PRE, TX_ADR, TX_FLG, TX_PLD, TX_CRC: begin
        if (st.tx_bitn == 3'd7) begin
          if (st.tx_state != TX_PRE && st.tx_state != TX_CRC) begin
            next_st.tx_crc = crc_nx;
          end
          next_st.tx_cnt = st.tx_cnt + 6'd1;
          unique case (st.tx_state)
            TX_PRE: begin
              next_st.tx_state = TX_ADR;
              next_st.tx_cnt   = '0;
              next_st.tx_sh    = st.tx_addr[7:0];
            end
            TX_ADR: begin
              if (st.tx_cnt == 6'd2) begin
                next_st.tx_state = TX_FLG;
                next_st.tx_sh    = {st.packet_sequence_tag, st.tx_is_ack,
                                    st.tx_is_ack ? 5'h00 : st.tx_length_minus_one};
              end else begin
                next_st.tx_sh = st.tx_addr[8*(st.tx_cnt[1:0] + 2'd1) +: 8];
              end
            end
            TX_FLG: begin
              next_st.tx_cnt = '0;
              if (st.tx_is_ack) begin
                next_st.tx_state = TX_CRC;
                next_st.tx_sh    = crc_nx[7:0];
                next_st.sent_crc = crc_nx;
              end else begin
                next_st.tx_state = TX_PLD;
                next_st.tx_sh    = tx_mem[0];
              end
            end
            TX_PLD: begin
              if (st.tx_cnt[4:0] == st.tx_length_minus_one) begin
                next_st.tx_state = TX_CRC;
                next_st.tx_cnt   = '0;
                next_st.tx_sh    = crc_nx[7:0];
                next_st.sent_crc = crc_nx;
              end else begin
                next_st.tx_sh = tx_mem[st.tx_cnt[4:0] + 5'd1];
              end
            end
            TX_CRC: begin
              if (st.tx_cnt == 6'd1) begin
                next_st.tx_state = TX_IDLE;
              end else begin
                next_st.tx_sh = st.sent_crc[15:8];
              end
            end
            default: next_st.tx_state = TX_IDLE;
          endcase
        end
      end
      default: next_st.tx_state = TX_IDLE;
    endcase

    // receiver
    if (rx_bit_valid) begin
      next_st.rx_sh   = rx_byte;
      next_st.rx_bitn = st.rx_bitn + 3'd1;
    end
    unique case (st.rx_state)
      RX_HUNT: begin
        next_st.rx_bitn = 3'd0;
        if (rx_bit_valid && ({rx_bit, st.rx_sh[7:1]} ==
                             (st.rx_addr[0] ? PREAMBLE_ONE : PREAMBLE_ZERO))) begin
          next_st.rx_state = RX_ADR;
          next_st.rx_cnt   = '0;
          next_st.rx_crc   = CRC_INIT;
        end
      end
      RX_ADR, RX_FLG, RX_PLD, RX_CRC: begin
        if (rx_byte_done) begin
          next_st.rx_cnt = st.rx_cnt + 6'd1;
          if (st.rx_state != RX_CRC) begin
            next_st.rx_crc = crc_byte(st.rx_crc, rx_byte);
          end
          unique case (st.rx_state)
            RX_ADR: begin
              if (rx_byte != st.rx_addr[8*st.rx_cnt[1:0] +: 8]) begin
                next_st.rx_state = RX_HUNT;
              end else if (st.rx_cnt == 6'd2) begin
                next_st.rx_state = RX_FLG;
              end
            end
            RX_FLG: begin
              next_st.rx_flags = rx_byte;
              next_st.rx_cnt   = '0;
              next_st.rx_state = rx_byte[FLAG_TYPE_BIT] ? RX_CRC : RX_PLD;
            end
            RX_PLD: begin
              if (st.rx_cnt[4:0] == st.rx_flags[4:0]) begin
                next_st.rx_state = RX_CRC;
                next_st.rx_cnt   = '0;
              end
            end
            RX_CRC: begin
              next_st.rx_got[8*st.rx_cnt[0] +: 8] = rx_byte;
              if (st.rx_cnt == 6'd1) begin
                next_st.rx_state = RX_HUNT;
                if (st.rx_flags[FLAG_TYPE_BIT]) begin
                  next_st.ack_received  = ({rx_byte, st.rx_got[7:0]} == st.rx_crc);
                  next_st.nack_received = ({rx_byte, st.rx_got[7:0]} != st.rx_crc);
                end else if ({rx_byte, st.rx_got[7:0]} != st.rx_crc) begin
                  next_st.rx_packet_error = 1'b1;
                end else begin
                  dup = st.last_valid && st.last_tag == st.rx_flags[7:6]
                        && st.last_crc == st.rx_crc;
                  if (!dup) begin
                    commit                      = 1'b1;
                    next_st.rx_packet_ok        = 1'b1;
                    next_st.rx_length_minus_one = st.rx_flags[4:0];
                    next_st.last_valid          = 1'b1;
                    next_st.last_tag            = st.rx_flags[7:6];
                    next_st.last_crc            = st.rx_crc;
                  end
                end
              end
            end
            default: next_st.rx_state = RX_HUNT;
          endcase
        end
      end
      default: next_st.rx_state = RX_HUNT;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st                     <= '0;
      st.tx_state            <= TX_IDLE;
      st.rx_state            <= RX_HUNT;
      st.tx_addr             <= ADDR_RESET;
      st.rx_addr             <= ADDR_RESET;
      st.tx_length_minus_one <= LEN_RESET;
      st.rx_length_minus_one <= LEN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign host_rdata      = st.host_rdata;
  assign tx_bit          = st.tx_bit;
  assign tx_active       = st.tx_active;
  assign rx_packet_ok    = st.rx_packet_ok;
  assign rx_packet_error = st.rx_packet_error;
  assign ack_received    = st.ack_received;
  assign nack_received   = st.nack_received;

endmodule // radio_packet_framer

//--- sim/radio_packet_framer_assertions.sv
// port-level checks for the radio packet framer
`timescale 1ns/1ps
module radio_packet_framer_assertions
  import radio_framer_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire host_req_s  host_req,
  input wire logic [7:0] host_rdata,
  input wire logic       tx_active,
  input wire logic       rx_bit_valid,
  input wire logic       rx_packet_ok,
  input wire logic       rx_packet_error,
  input wire logic       ack_received,
  input wire logic       nack_received
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [9:0] run_len;
  logic       any_pulse;
  logic       ctrl_go;
  assign any_pulse = rx_packet_ok | rx_packet_error | ack_received | nack_received;
  assign ctrl_go   = host_req.wr && host_req.addr == CTRL_OFS && host_req.wdata[2:0] != 3'h0;
  always_ff @(posedge core_clk) begin
    if (srst || !tx_active)
      run_len <= 10'h000;
    else
      run_len <= run_len + 10'h001;
  end
  chk_reset_quiet: assert property (
    $past(srst) |-> !tx_active && !any_pulse && host_rdata == 8'h00) else $error("outputs busy after reset");
  chk_tx_start: assert property (
    ctrl_go && !tx_active |=> tx_active) else $error("control write did not start tx");
  chk_tx_cause: assert property (
    $rose(tx_active) |-> $past(ctrl_go)) else $error("tx started without control write");
  // one lead cycle, then 56 (ack) to 312 bits in whole bytes
  chk_tx_length: assert property (
    $fell(tx_active) && !$past(srst) |-> run_len[2:0] == 3'h1 && run_len >= 10'd57 && run_len <= 10'd313)
    else $error("tx frame length not whole packet");
  chk_pulse_onehot: assert property (
    $onehot0({rx_packet_ok, rx_packet_error, ack_received, nack_received})) else $error("two rx results at once");
  chk_pulse_single: assert property (
    any_pulse |=> !any_pulse) else $error("rx result longer than a pulse");
  chk_pulse_cause: assert property (
    any_pulse |-> $past(rx_bit_valid)) else $error("rx result without final bit");
  chk_rdata_hold: assert property (
    !$past(host_req.rd) && !$past(srst) |-> $stable(host_rdata)) else $error("read data moved without read");
  chk_unmapped_zero: assert property (
    host_req.rd && host_req.addr inside {[7'h16:7'h2f]} |=> host_rdata == 8'h00) else $error("unmapped read not zero");
  cover property (rx_packet_ok);
  cover property (nack_received);
  cover property ($fell(tx_active));
endmodule  // radio_packet_framer_assertions

bind radio_packet_framer radio_packet_framer_assertions u_chk (.core_clk(core_clk), .srst(srst), .host_req(host_req),
  .host_rdata(host_rdata), .tx_active(tx_active), .rx_bit_valid(rx_bit_valid), .rx_packet_ok(rx_packet_ok),
  .rx_packet_error(rx_packet_error), .ack_received(ack_received), .nack_received(nack_received));

//--- sim/peer_radio_model.sv
// peer transceiver: frames packets onto the rx line, records the tx line
`timescale 1ns/1ps
module peer_radio_model
  import radio_framer_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic tx_bit,
  input  wire logic tx_active,
  output logic      rx_bit_valid,
  output logic      rx_bit
);
  logic cap[$];
  logic was_active;
  initial begin
    rx_bit_valid = 1'b0;
    rx_bit       = 1'b0;
    was_active   = 1'b0;
  end
  // first active cycle carries no bit yet
  always @(posedge core_clk) begin
    if (tx_active && was_active)
      cap.push_back(tx_bit);
    was_active <= tx_active;
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  function automatic void build(input logic [23:0] a, input logic [7:0] flg, input logic [7:0] p[$],
                                input logic bad, output logic q[$]);
    logic [7:0]  by[$];
    logic [15:0] c;
    by = {a[7:0], a[15:8], a[23:16], flg};
    by = {by, p};
    c = CRC_INIT;
    foreach (by[i])
      c = crc_step(c, by[i]);
    c[0] = c[0] ^ bad;
    by = {a[0] ? PREAMBLE_ONE : PREAMBLE_ZERO, by, c[7:0], c[15:8]};
    q = {};
    foreach (by[i])
      for (int b = 0; b < 8; b++)
        q.push_back(by[i][b]);
  endfunction
  // zero lead-in stops a stale bit tail faking an early preamble
  task automatic send(input logic [23:0] a, input logic [7:0] flg, input logic [7:0] p[$], input logic bad);
    logic q[$];
    build(a, flg, p, bad, q);
    repeat (8) q.push_front(1'b0);
    foreach (q[i]) begin
      @(posedge core_clk);
      rx_bit_valid <= 1'b1;
      rx_bit       <= q[i];
    end
    @(posedge core_clk);
    rx_bit_valid <= 1'b0;
    rx_bit       <= ~q[q.size() - 1];
  endtask
endmodule  // peer_radio_model

//--- sim/radio_packet_framer_test.sv
// self-checking bench for the radio packet framer
`timescale 1ns/1ps
module radio_packet_framer_test;
  import radio_framer_pkg::*;
  typedef struct packed {logic [6:0] a; logic [7:0] v;} row_s;
  logic       core_clk, srst, tx_bit, tx_active, rx_bit_valid, rx_bit;
  logic [7:0] host_rdata;
  logic [3:0] pulse;
  logic [1:0] tag;
  logic [7:0] pl[$], none[$];
  host_req_s  host_req;
  int         n_errors, n_compared, hits[4], snap[4];
  row_s       rows[9] = '{'{7'h0e, 8'h5b}, '{7'h0f, 8'h34}, '{7'h10, 8'h12}, '{7'h11, 8'h5b}, '{7'h12, 8'h34},
                          '{7'h13, 8'h12}, '{7'h14, 8'h00}, '{7'h15, 8'h00}, '{7'h20, 8'h00}};
  radio_packet_framer u_radio_packet_framer (.core_clk(core_clk), .srst(srst), .host_req(host_req),
    .host_rdata(host_rdata), .tx_bit(tx_bit), .tx_active(tx_active), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_packet_ok(pulse[0]), .rx_packet_error(pulse[1]), .ack_received(pulse[2]), .nack_received(pulse[3]));
  peer_radio_model u_peer_radio_model (.core_clk(core_clk), .tx_bit(tx_bit), .tx_active(tx_active),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    foreach (pulse[k])
      if (pulse[k] === 1'b1)
        hits[k]++;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_req <= host_req_s'{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    host_req <= '0;
  endtask
  // successive reads at successive addresses, no gap
  task automatic rd(input logic [6:0] a, input logic [7:0] exp[$]);
    for (int i = 0; i < exp.size() + 2; i++) begin
      @(posedge core_clk);
      if (i >= 2) check("host_rdata", {8'h00, host_rdata}, {8'h00, exp[i-2]});
      host_req <= (i < exp.size()) ? host_req_s'{1'b0, 1'b1, a + 7'(i), 8'h00} : '0;
    end
  endtask
  task automatic reset_rows();
    foreach (rows[i])
      rd(rows[i].a, {rows[i].v});
  endtask
  task automatic tx_check(input logic [7:0] ctrl, input logic typ, input logic [7:0] p[$], input logic [23:0] adr,
                          input logic want, input logic [1:0] want_tag);
    logic q[$];
    int   d;
    d = 0;
    u_peer_radio_model.cap = {};
    wr(CTRL_OFS, ctrl);
    repeat (12) @(posedge core_clk);
    wr(CTRL_OFS, 8'h01);
    for (int i = 0; i < 400 && tx_active === 1'b1; i++)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    check("tx_idle", {15'h0, tx_active}, 16'h0);
    tag = {u_peer_radio_model.cap[39], u_peer_radio_model.cap[38]};
    if (want) check("tx_tag", {14'h0, tag}, {14'h0, want_tag});
    u_peer_radio_model.build(adr, {tag, typ, typ ? 5'h00 : 5'(p.size() - 1)}, p, 1'b0, q);
    check("tx_bits", 16'(u_peer_radio_model.cap.size()), 16'(q.size()));
    foreach (q[i])
      if (u_peer_radio_model.cap[i] !== q[i])
        d++;
    check("tx_frame", 16'(d), 16'h0);
  endtask
  task automatic rx_case(input logic [23:0] a, input logic [7:0] flg, input logic [7:0] p[$], input logic bad,
                         input logic [3:0] exp);
    snap = hits;
    u_peer_radio_model.send(a, flg, p, bad);
    repeat (4) @(posedge core_clk);
    foreach (hits[k])
      check("rx_result", 16'(hits[k] - snap[k]), {15'h0, exp[k]});
  endtask
  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    host_req = '0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    reset_rows();
    for (int i = 0; i < 32; i++)
      pl.push_back(8'(8'h11 * i + 8'h03));
    for (int i = 0; i < 32; i++)
      wr(TX_BUF_BASE + 7'(i), pl[i]);
    wr(TX_LEN_OFS, 8'h1f);
    tx_check(8'h01, 1'b0, pl, ADDR_RESET, 1'b1, 2'h1);
    tx_check(8'h02, 1'b0, pl, ADDR_RESET, 1'b1, tag);
    wr(TX_LEN_OFS, 8'h00);
    wr(TX_ADDR_OFS, 8'h5a);
    tx_check(8'h01, 1'b0, pl[0:0], 24'h12345a, 1'b1, tag + 2'h1);
    tx_check(8'h04, 1'b1, none, 24'h12345a, 1'b0, 2'h0);
    rx_case(ADDR_RESET, 8'h44, pl[0:4], 1'b0, 4'b0001);
    rd(RX_BUF_BASE, pl[0:4]);
    rd(RX_LEN_OFS, {8'h04});
    rx_case(ADDR_RESET, 8'h44, pl[0:4], 1'b0, 4'b0000);
    rx_case(ADDR_RESET, 8'h9f, pl, 1'b0, 4'b0001);
    rd(RX_BUF_BASE, pl);
    rd(RX_LEN_OFS, {8'h1f});
    rx_case(ADDR_RESET, 8'hdf, pl, 1'b1, 4'b0010);
    rx_case(ADDR_RESET, 8'h20, none, 1'b0, 4'b0100);
    rx_case(ADDR_RESET, 8'h20, none, 1'b1, 4'b1000);
    rx_case(24'h12345a, 8'h04, pl[0:4], 1'b0, 4'b0000);
    wr(RX_BUF_BASE, 8'h00);
    rd(RX_BUF_BASE, pl[0:0]);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    reset_rows();
    rd(RX_BUF_BASE, pl[0:0]);
    tally_and_finish();
  end
endmodule  // radio_packet_framer_test
